// ---- core/motor_protect_defines.svh ----
// offsets, field positions, reset values and timing counts of the supervisor
// assumes a 40 MHz clock and a 16-bit word-indexed register port
`ifndef MOTOR_PROTECT_DEFINES_SVH
`define MOTOR_PROTECT_DEFINES_SVH
`define CLK_HZ          40_000_000
`define TICK_MS         100
`define MINUTE_TICKS    600
`define CORNER_FREQ     16'h0BB8
`define OL_CHOICE       3'h1
`define REG_CFG         4'h0
`define REG_NM_LEVEL    4'h1
`define REG_NM_TIME     4'h2
`define REG_TH_1MIN     4'h3
`define REG_TH_CONT     4'h4
`define REG_WARN_LEVEL  4'h5
`define REG_WARN_TIME   4'h6
`define REG_TRIP_LEVEL  4'h7
`define REG_TRIP_TIME   4'h8
`define REG_STALL_LEVEL 4'h9
`define REG_RAMP_FREQ   4'hA
`define REG_BASE_FREQ   4'hB
`define REG_STATUS      4'hC
`define REG_COMMAND     4'hD
`define CMD_FAULT_RESET 0
`define RST_CFG         16'h0002
`define RST_NM_LEVEL    10'h005
`define RST_NM_TIME     10'h01E
`define RST_TH_1MIN     10'h096
`define RST_TH_CONT     10'h064
`define RST_WARN_LEVEL  10'h096
`define RST_WARN_TIME   10'h064
`define RST_TRIP_LEVEL  10'h0B4
`define RST_TRIP_TIME   10'h258
`define RST_STALL_LEVEL 10'h096
`define RST_RAMP_FREQ   16'h0000
`define RST_BASE_FREQ   16'h1770
`endif

// ---- core/motor_protect_pkg.sv ----
// types shared by the protection supervisor
// field layout of the configuration word, trip causes
package motor_protect_pkg;
  typedef struct packed {
    logic [3:0] spare;
    logic [2:0] aux_select;
    logic [2:0] stall_mode_bits;
    logic [2:0] phase_loss_protect_bits;
    logic       motor_cooling_type;
    logic       thermal_enable;
    logic       no_motor_select;
  } cfg_t;
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_NO_MOTOR, CAUSE_THERMAL, CAUSE_OVERLOAD,
    CAUSE_OUT_PHASE, CAUSE_IN_PHASE
  } trip_cause_t;
  typedef struct packed {
    logic       accel;
    logic       steady;
    logic       decel;
    logic       stop_cmd;
  } drive_phase_t;
endpackage

// ---- core/motor_drive_protection_supervisor.sv ----
// protection supervisor: current thresholds, timers, thermal model, stall
// assumes current and frequency come from logic on the same clock
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "motor_protect_defines.svh"
module motor_drive_protection_supervisor
  import motor_protect_pkg::*;
#(
  parameter int TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [9:0]  current_pct,
  input  wire logic [15:0] out_freq,
  input  wire drive_phase_t drive_phase,
  input  wire logic        running,
  input  wire logic        heatsink_hot,
  input  wire logic        out_phase_loss,
  input  wire logic        in_phase_loss,
  input  wire logic        exchange_active,
  input  wire logic [2:0]  ramp_select_pins,
  output logic             output_cutoff,
  output trip_cause_t      trip_cause,
  output logic             aux_contact_output,
  output logic             stall_lower_freq,
  output logic             decel_request,
  output logic [2:0]       ramp_index
);
  cfg_t        cfg_ff;
  logic [9:0]  no_motor_level_ff, no_motor_time_ff;
  logic [9:0]  thermal_one_minute_level_ff, thermal_continuous_level_ff;
  logic [9:0]  overload_warn_level_ff, overload_warn_time_ff;
  logic [9:0]  overload_trip_level_ff, overload_trip_time_ff;
  logic [9:0]  stall_level_ff;
  logic [15:0] ramp_change_frequency_ff, base_freq_ff;
  logic [15:0] rdata_ff;
  logic        fault_reset;
  logic [21:0] tick_cnt_ff;
  logic        tick_ff;
  logic [6:0]  sync1_ff, sync2_ff;
  logic        heat_s, out_loss_s, in_loss_s, exch_s;
  logic [2:0]  ramp_sel_s;
  logic [9:0]  nm_cnt_ff, warn_cnt_ff, warn_hold_ff, ol_cnt_ff;
  logic        alarm_ff;
  logic [29:0] eth_acc_ff, eth_limit;
  logic [9:0]  cont_eff;
  logic [9:0]  stall_eff;
  logic        stall_ff;
  logic        cutoff_ff;
  trip_cause_t cause_ff, nxt_cause;
  logic        aux_ff, decel_ff;
  logic [2:0]  ramp_idx_ff;
  logic        protect_on, stall_phase_on;

  // saturating tick timer: counts while cond holds, clears otherwise
  function automatic logic [9:0] tmr_next(input logic [9:0] cnt,
                                          input logic cond,
                                          input logic tick);
    if (!cond)
      return 10'h000;
    else if (tick && cnt != 10'h3FF)
      return cnt + 10'h001;
    else
      return cnt;
  endfunction

  function automatic logic [19:0] sq(input logic [9:0] v);
    return v * v;
  endfunction

  assign fault_reset = reg_wr && reg_addr == `REG_COMMAND
                       && reg_wdata[`CMD_FAULT_RESET];

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_ff                      <= `RST_CFG;
      no_motor_level_ff           <= `RST_NM_LEVEL;
      no_motor_time_ff            <= `RST_NM_TIME;
      thermal_one_minute_level_ff <= `RST_TH_1MIN;
      thermal_continuous_level_ff <= `RST_TH_CONT;
      overload_warn_level_ff      <= `RST_WARN_LEVEL;
      overload_warn_time_ff       <= `RST_WARN_TIME;
      overload_trip_level_ff      <= `RST_TRIP_LEVEL;
      overload_trip_time_ff       <= `RST_TRIP_TIME;
      stall_level_ff              <= `RST_STALL_LEVEL;
      ramp_change_frequency_ff    <= `RST_RAMP_FREQ;
      base_freq_ff                <= `RST_BASE_FREQ;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `REG_CFG:         cfg_ff <= reg_wdata;
        `REG_NM_LEVEL:    no_motor_level_ff <= reg_wdata[9:0];
        `REG_NM_TIME:     no_motor_time_ff <= reg_wdata[9:0];
        `REG_TH_1MIN:     thermal_one_minute_level_ff <= reg_wdata[9:0];
        `REG_TH_CONT:     thermal_continuous_level_ff <= reg_wdata[9:0];
        `REG_WARN_LEVEL:  overload_warn_level_ff <= reg_wdata[9:0];
        `REG_WARN_TIME:   overload_warn_time_ff <= reg_wdata[9:0];
        `REG_TRIP_LEVEL:  overload_trip_level_ff <= reg_wdata[9:0];
        `REG_TRIP_TIME:   overload_trip_time_ff <= reg_wdata[9:0];
        `REG_STALL_LEVEL: stall_level_ff <= reg_wdata[9:0];
        `REG_RAMP_FREQ:   ramp_change_frequency_ff <= reg_wdata;
        `REG_BASE_FREQ:   base_freq_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads 0
  always_ff @(posedge clock) begin
    if (rst || !reg_rd) begin
      rdata_ff <= 16'h0000;
    end else begin
      unique case (reg_addr)
        `REG_CFG:         rdata_ff <= cfg_ff;
        `REG_NM_LEVEL:    rdata_ff <= {6'h00, no_motor_level_ff};
        `REG_NM_TIME:     rdata_ff <= {6'h00, no_motor_time_ff};
        `REG_TH_1MIN:     rdata_ff <= {6'h00, thermal_one_minute_level_ff};
        `REG_TH_CONT:     rdata_ff <= {6'h00, thermal_continuous_level_ff};
        `REG_WARN_LEVEL:  rdata_ff <= {6'h00, overload_warn_level_ff};
        `REG_WARN_TIME:   rdata_ff <= {6'h00, overload_warn_time_ff};
        `REG_TRIP_LEVEL:  rdata_ff <= {6'h00, overload_trip_level_ff};
        `REG_TRIP_TIME:   rdata_ff <= {6'h00, overload_trip_time_ff};
        `REG_STALL_LEVEL: rdata_ff <= {6'h00, stall_level_ff};
        `REG_RAMP_FREQ:   rdata_ff <= ramp_change_frequency_ff;
        `REG_BASE_FREQ:   rdata_ff <= base_freq_ff;
        `REG_STATUS:      rdata_ff <= {6'h00, ramp_idx_ff, stall_ff,
                                       alarm_ff, cutoff_ff, 1'b0, cause_ff};
        default:          rdata_ff <= 16'h0000;
      endcase
    end
  end

  // 0.1 s time base shared by every protection timer
  always_ff @(posedge clock) begin
    if (rst || tick_cnt_ff == 22'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 22'h00_0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 22'h00_0001;
    end
    tick_ff <= !rst && tick_cnt_ff == 22'(TICK_CYCLES - 1);
  end

  // pins from the power stage are asynchronous to the clock
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
    end else begin
      sync1_ff <= {ramp_select_pins, exchange_active, in_phase_loss,
                   out_phase_loss, heatsink_hot};
      sync2_ff <= sync1_ff;
    end
  end
  assign {ramp_sel_s, exch_s, in_loss_s, out_loss_s, heat_s} = sync2_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      nm_cnt_ff <= 10'h000;
    end else begin
      nm_cnt_ff <= tmr_next(nm_cnt_ff, cfg_ff.no_motor_select && running
                            && current_pct < no_motor_level_ff, tick_ff);
    end
  end

  // overload timer only runs while the heatsink is hot
  always_ff @(posedge clock) begin
    if (rst) begin
      ol_cnt_ff <= 10'h000;
    end else begin
      ol_cnt_ff <= tmr_next(ol_cnt_ff, heat_s
                            && current_pct > overload_trip_level_ff,
                            tick_ff);
    end
  end

  // self-cooled derating: half level at standstill, full at the corner
  always_comb begin
    cont_eff = thermal_continuous_level_ff;
    if (!cfg_ff.motor_cooling_type && out_freq < `CORNER_FREQ) begin
      cont_eff = 10'((thermal_continuous_level_ff >> 1)
                 + (26'(thermal_continuous_level_ff) * out_freq)
                   / (2 * `CORNER_FREQ));
    end
  end
  // limit reached by a one-minute-level current after one minute;
  // assumes the continuous level sits below the one-minute level
  assign eth_limit = 30'(sq(thermal_one_minute_level_ff)
                     - sq(thermal_continuous_level_ff)) * 30'(`MINUTE_TICKS);

  always_ff @(posedge clock) begin
    if (rst) begin
      eth_acc_ff <= 30'h0000_0000;
    end else if (tick_ff) begin
      // heat integrates across load steps; cooling drains toward zero
      if (sq(current_pct) >= sq(cont_eff)) begin
        if (eth_acc_ff + 30'(sq(current_pct) - sq(cont_eff)) >= eth_limit)
          eth_acc_ff <= eth_limit;
        else
          eth_acc_ff <= eth_acc_ff + 30'(sq(current_pct) - sq(cont_eff));
      end else if (eth_acc_ff > 30'(sq(cont_eff) - sq(current_pct))) begin
        eth_acc_ff <= eth_acc_ff - 30'(sq(cont_eff) - sq(current_pct));
      end else begin
        eth_acc_ff <= 30'h0000_0000;
      end
    end
  end

  // alarm hold reloads while the current stays high
  always_ff @(posedge clock) begin
    if (rst) begin
      warn_cnt_ff  <= 10'h000;
      warn_hold_ff <= 10'h000;
      alarm_ff     <= 1'b0;
    end else begin
      warn_cnt_ff <= tmr_next(warn_cnt_ff,
                              current_pct >= overload_warn_level_ff, tick_ff);
      if (warn_cnt_ff >= overload_warn_time_ff
          && current_pct >= overload_warn_level_ff) begin
        alarm_ff     <= 1'b1;
        warn_hold_ff <= overload_warn_time_ff;
      end else if (alarm_ff && tick_ff) begin
        warn_hold_ff <= warn_hold_ff - 10'h001;
        alarm_ff     <= warn_hold_ff > 10'h001;
      end
    end
  end

  assign protect_on = !exch_s || cfg_ff.phase_loss_protect_bits[2];

  always_comb begin
    nxt_cause = CAUSE_NONE;
    if (nm_cnt_ff >= no_motor_time_ff && nm_cnt_ff != 10'h000)
      nxt_cause = CAUSE_NO_MOTOR;
    else if (cfg_ff.thermal_enable && eth_limit != 30'h0000_0000
             && eth_acc_ff >= eth_limit)
      nxt_cause = CAUSE_THERMAL;
    else if (ol_cnt_ff >= overload_trip_time_ff && ol_cnt_ff != 10'h000)
      nxt_cause = CAUSE_OVERLOAD;
    else if (out_loss_s && protect_on && cfg_ff.phase_loss_protect_bits[0])
      nxt_cause = CAUSE_OUT_PHASE;
    else if (in_loss_s && protect_on && cfg_ff.phase_loss_protect_bits[1])
      nxt_cause = CAUSE_IN_PHASE;
  end

  // a trip arriving with the reset wins and stays latched
  always_ff @(posedge clock) begin
    if (rst) begin
      cutoff_ff <= 1'b0;
      cause_ff  <= CAUSE_NONE;
    end else if (!cutoff_ff && nxt_cause != CAUSE_NONE) begin
      cutoff_ff <= 1'b1;
      cause_ff  <= nxt_cause;
    end else if (fault_reset) begin
      cutoff_ff <= nxt_cause != CAUSE_NONE;
      cause_ff  <= nxt_cause;
    end
  end

  assign stall_phase_on = (cfg_ff.stall_mode_bits[0] && drive_phase.accel)
                        || (cfg_ff.stall_mode_bits[1] && drive_phase.steady)
                        || (cfg_ff.stall_mode_bits[2] && drive_phase.decel);
  assign stall_eff = out_freq > base_freq_ff
                   ? stall_level_ff - (stall_level_ff >> 2)
                   : stall_level_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      stall_ff    <= 1'b0;
      decel_ff    <= 1'b0;
      aux_ff      <= 1'b0;
      ramp_idx_ff <= 3'h0;
    end else begin
      stall_ff <= running && stall_phase_on && current_pct > stall_eff;
      decel_ff <= stall_ff && drive_phase.stop_cmd;
      aux_ff   <= alarm_ff && cfg_ff.aux_select == `OL_CHOICE;
      if (ramp_sel_s != 3'h0)
        ramp_idx_ff <= ramp_sel_s;
      else
        ramp_idx_ff <= {2'h0, ramp_change_frequency_ff != 16'h0000
                        && out_freq >= ramp_change_frequency_ff};
    end
  end

  assign reg_rdata          = rdata_ff;
  assign output_cutoff      = cutoff_ff;
  assign trip_cause         = cause_ff;
  assign aux_contact_output = aux_ff;
  assign stall_lower_freq   = stall_ff;
  assign decel_request      = decel_ff;
  assign ramp_index         = ramp_idx_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence trip_due_s;
    !cutoff_ff && nxt_cause != CAUSE_NONE;
  endsequence
  sequence trip_latched_s;
    cutoff_ff && cause_ff == $past(nxt_cause);
  endsequence

  trip_hold_a: assert property (cutoff_ff && !fault_reset |=> cutoff_ff)
    else $error("latched trip dropped without reset");
  trip_take_a: assert property (trip_due_s |=> trip_latched_s)
    else $error("trip cause not latched");
  no_motor_a: assert property (!cutoff_ff && nm_cnt_ff != 10'h000
      && nm_cnt_ff >= no_motor_time_ff |=> cause_ff == CAUSE_NO_MOTOR)
    else $error("no-motor trip missed");
  thermal_a: assert property (!cutoff_ff && nxt_cause == CAUSE_THERMAL
      |=> cutoff_ff && cause_ff == CAUSE_THERMAL)
    else $error("thermal trip missed");
  heat_gate_a: assert property (ol_cnt_ff > $past(ol_cnt_ff)
      |-> $past(heat_s))
    else $error("overload timer ran while heatsink cool");
  out_phase_a: assert property (!cutoff_ff && nxt_cause == CAUSE_NONE
      ##1 !cutoff_ff && out_loss_s && !cfg_ff.phase_loss_protect_bits[0]
      |-> nxt_cause != CAUSE_OUT_PHASE)
    else $error("output phase trip while disabled");
  in_phase_a: assert property (in_loss_s && protect_on
      && cfg_ff.phase_loss_protect_bits[1] && !cutoff_ff |=> cutoff_ff)
    else $error("input phase loss ignored");
  alarm_hold_a: assert property (alarm_ff && warn_hold_ff > 10'h001
      |=> alarm_ff)
    else $error("alarm dropped before hold time");
  aux_gate_a: assert property (aux_contact_output
      |-> $past(alarm_ff) && $past(cfg_ff.aux_select) == `OL_CHOICE)
    else $error("aux contact driven without overload choice");
  stall_phase_a: assert property (stall_ff |-> $past(stall_phase_on))
    else $error("stall active in disabled phase");
  stop_decel_a: assert property (stall_ff && drive_phase.stop_cmd
      |=> decel_request)
    else $error("stop in stall did not decelerate");
  ramp_multi_a: assert property (ramp_sel_s != 3'h0
      |=> ramp_index == $past(ramp_sel_s))
    else $error("multi-ramp select lost priority");
endmodule

// ---- verification/inverter_stage_model.sv ----
// power stage and current sensing that face the protection supervisor
// assumes the bench loads operating points; the async pins stay with it
`timescale 1ns/1ps
module inverter_stage_model
  import motor_protect_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         ld,
  input  wire logic [9:0]   cur_set,
  input  wire logic [15:0]  freq_set,
  input  wire drive_phase_t phase_set,
  input  wire logic         run_set,
  input  wire logic         stiff,
  input  wire logic         output_cutoff,
  input  wire logic         stall_lower_freq,
  output logic [9:0]        current_pct,
  output logic [15:0]       out_freq,
  output drive_phase_t      drive_phase,
  output logic              running
);
  logic [9:0]   cur_ff;
  logic [15:0]  freq_ff;
  drive_phase_t phase_ff;
  logic         run_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      cur_ff   <= 10'h000;
      freq_ff  <= 16'h0000;
      phase_ff <= 4'h0;
      run_ff   <= 1'b0;
    end else if (ld) begin
      cur_ff   <= cur_set;
      freq_ff  <= freq_set;
      phase_ff <= phase_set;
      run_ff   <= run_set;
    end else if (output_cutoff) begin
      // a stage whose output is cut carries no current at all
      cur_ff <= 10'h000;
      run_ff <= 1'b0;
    end else if (stall_lower_freq && !stiff && freq_ff != 16'h0000
                 && cur_ff != 10'h000) begin
      // slowing sheds load current; stiff stands for a jammed load
      freq_ff <= freq_ff - 16'h0001;
      cur_ff  <= cur_ff - 10'h001;
    end
  end

  assign current_pct = cur_ff;
  assign out_freq    = freq_ff;
  assign drive_phase = phase_ff;
  assign running     = run_ff;
endmodule

// ---- verification/motor_drive_protection_supervisor_tb.sv ----
// self-checking bench of the protection supervisor
// assumes a short tick so that thermal and timer runs stay brief
`timescale 1ns/1ps
`include "motor_protect_defines.svh"
module motor_drive_protection_supervisor_tb
  import motor_protect_pkg::*;
;
  logic         clock, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]   reg_addr = 4'h0;
  logic [15:0]  reg_wdata = 16'h0000, reg_rdata, out_freq, d;
  logic [9:0]   current_pct, cur_set = 10'h000;
  logic [15:0]  freq_set = 16'h0000;
  drive_phase_t drive_phase, phase_set = 4'h0;
  logic         running, run_set = 1'b0, ld = 1'b0, stiff = 1'b0;
  logic         heatsink_hot = 1'b0, out_phase_loss = 1'b0;
  logic         in_phase_loss = 1'b0, exchange_active = 1'b0;
  logic [2:0]   ramp_select_pins = 3'b000, ramp_index;
  logic         output_cutoff, aux_contact_output;
  logic         stall_lower_freq, decel_request;
  trip_cause_t  trip_cause;
  int           error_cnt = 0, compares = 0, i, m, k, n;
  logic [15:0]  dflt [12] = '{16'h0002, 16'h0005, 16'h001E, 16'h0096,
    16'h0064, 16'h0096, 16'h0064, 16'h00B4, 16'h0258, 16'h0096,
    16'h0000, 16'h1770};
  logic [15:0]  pcfg [5] = '{16'h0008, 16'h0010, 16'h0000, 16'h0018,
    16'h0038};
  logic         pin_in [5] = '{0, 1, 0, 0, 0};
  logic         pex [5] = '{0, 0, 0, 1, 1};
  logic [2:0]   pexp [5] = '{3'h4, 3'h5, 3'h0, 3'h0, 3'h4};
  logic [15:0]  tcfg [3] = '{16'h0006, 16'h0002, 16'h0002};
  logic [15:0]  tfq [3] = '{16'h0000, 16'h0000, 16'h05DC};
  int           tlo [3] = '{5980, 3730, 4380};
  int           thi [3] = '{6030, 3780, 4520};

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  motor_drive_protection_supervisor #(.TICK_CYCLES(10)) u_dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .current_pct(current_pct), .out_freq(out_freq),
    .drive_phase(drive_phase), .running(running),
    .heatsink_hot(heatsink_hot), .out_phase_loss(out_phase_loss),
    .in_phase_loss(in_phase_loss), .exchange_active(exchange_active),
    .ramp_select_pins(ramp_select_pins), .output_cutoff(output_cutoff),
    .trip_cause(trip_cause), .aux_contact_output(aux_contact_output),
    .stall_lower_freq(stall_lower_freq), .decel_request(decel_request),
    .ramp_index(ramp_index));

  inverter_stage_model u_stage (
    .clock(clock), .rst(rst), .ld(ld), .cur_set(cur_set),
    .freq_set(freq_set), .phase_set(phase_set), .run_set(run_set),
    .stiff(stiff), .output_cutoff(output_cutoff),
    .stall_lower_freq(stall_lower_freq), .current_pct(current_pct),
    .out_freq(out_freq), .drive_phase(drive_phase), .running(running));

  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chkb(input string nm, input logic seen, exp);
    chk(nm, {15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic in_range(input string nm, input int v, lo, hi);
    chkb(nm, v >= lo && v <= hi, 1'b1);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] r);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    r = reg_rdata;
  endtask

  task automatic load(input logic [9:0] c, input logic [15:0] f,
                      input drive_phase_t p, input logic r);
    @(posedge clock);
    cur_set   <= c;
    freq_set  <= f;
    phase_set <= p;
    run_set   <= r;
    ld        <= 1'b1;
    @(posedge clock);
    ld <= 1'b0;
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = output_cutoff;
      1: pick = aux_contact_output;
      3: pick = decel_request;
      4: pick = !aux_contact_output;
      default: pick = !stall_lower_freq;
    endcase
  endfunction

  // cycles until the picked output goes high; mx when it never does
  task automatic time_to(input int s, input int mx, output int c);
    for (c = 0; c < mx; c++) begin
      @(posedge clock);
      #1;
      if (pick(s) === 1'b1) break;
    end
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst              <= 1'b1;
    heatsink_hot     <= 1'b0;
    out_phase_loss   <= 1'b0;
    in_phase_loss    <= 1'b0;
    exchange_active  <= 1'b0;
    ramp_select_pins <= 3'b000;
    stiff            <= 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end

  initial begin
    do_reset();
    for (i = 0; i < 12; i++) begin
      rd(i[3:0], d);
      chk("reg", d, dflt[i]);
    end
    rd(4'hE, d);
    chk("unmapped", d, 16'h0000);
    load(10'h002, 16'h0BB8, 4'b0100, 1'b1);
    idle(400);
    chkb("nm_off", output_cutoff, 1'b0);
    do_reset();
    wr(`REG_NM_TIME, 16'h0003);
    wr(`REG_CFG, 16'h0001);
    load(10'h002, 16'h0BB8, 4'b0100, 1'b1);
    time_to(0, 80, n);
    in_range("nm_lat", n, 20, 45);
    chk("cause", 16'(trip_cause), 16'(CAUSE_NO_MOTOR));
    for (i = 0; i < 5; i++) begin
      do_reset();
      wr(`REG_CFG, pcfg[i]);
      @(posedge clock);
      exchange_active <= pex[i];
      out_phase_loss  <= !pin_in[i];
      in_phase_loss   <= pin_in[i];
      idle(6);
      chkb("cut", output_cutoff, pexp[i] != 3'h0);
      chk("cause", 16'(trip_cause), 16'(pexp[i]));
      @(posedge clock);
      out_phase_loss <= 1'b0;
      in_phase_loss  <= 1'b0;
      idle(6);
      chkb("held", output_cutoff, pexp[i] != 3'h0);
      wr(`REG_COMMAND, 16'h0001);
      idle(2);
      chkb("cleared", output_cutoff, 1'b0);
    end
    do_reset();
    wr(`REG_TRIP_TIME, 16'h0004);
    wr(`REG_CFG, 16'h0000);
    load(10'h0C8, 16'h0BB8, 4'b0100, 1'b1);
    idle(100);
    chkb("cool", output_cutoff, 1'b0);
    @(posedge clock);
    heatsink_hot <= 1'b1;
    time_to(0, 80, n);
    in_range("ol_lat", n, 30, 60);
    chk("cause", 16'(trip_cause), 16'(CAUSE_OVERLOAD));
    // continuous level stays at its default, below the one-minute level
    for (i = 0; i < 3; i++) begin
      do_reset();
      wr(`REG_CFG, tcfg[i]);
      load(10'h096, tfq[i], 4'b0100, 1'b1);
      time_to(0, 7000, n);
      in_range("th_lat", n, tlo[i], thi[i]);
      chk("cause", 16'(trip_cause), 16'(CAUSE_THERMAL));
    end
    // heat stored at 150 percent must carry over into the 200 percent step
    do_reset();
    wr(`REG_CFG, 16'h0006);
    load(10'h096, 16'h0000, 4'b0100, 1'b1);
    idle(3000);
    load(10'h0C8, 16'h0000, 4'b0100, 1'b1);
    time_to(0, 2000, n);
    in_range("th_step", n, 1200, 1300);
    chkb("th_cut", output_cutoff, 1'b1);
    for (i = 0; i < 2; i++) begin
      do_reset();
      wr(`REG_WARN_TIME, 16'h0003);
      wr(`REG_CFG, (i == 1) ? 16'h0200 : 16'h0000);
      load(10'h0A0, 16'h0BB8, 4'b0100, 1'b1);
      time_to(1, 60, n);
      in_range("al_lat", n, i ? 20 : 60, i ? 45 : 60);
      rd(`REG_STATUS, d);
      chk("al_stat", d & 16'h0020, 16'h0020);
      load(10'h000, 16'h0BB8, 4'b0100, 1'b1);
      time_to(4, 60, n);
      in_range("al_hold", n, i ? 20 : 0, i ? 45 : 0);
    end
    do_reset();
    stiff <= 1'b1;
    for (m = 0; m < 4; m++) begin
      wr(`REG_CFG, (m == 3) ? 16'h01C0 : 16'h0040 << m);
      for (k = 0; k < 3; k++) begin
        load(10'h0C8, 16'h0BB8, 4'(4'b1000 >> k), 1'b1);
        idle(4);
        chkb("stall", stall_lower_freq, m == 3 || m == k);
      end
    end
    load(10'h082, 16'h1964, 4'b0100, 1'b1);
    idle(4);
    chkb("st_hi", stall_lower_freq, 1'b1);
    load(10'h082, 16'h0BB8, 4'b0100, 1'b1);
    idle(4);
    chkb("st_lo", stall_lower_freq, 1'b0);
    load(10'h0C8, 16'h0BB8, 4'b0101, 1'b1);
    time_to(3, 8, n);
    chkb("decel", decel_request, 1'b1);
    @(posedge clock);
    stiff <= 1'b0;
    load(10'h0C8, 16'h0BB8, 4'b0100, 1'b1);
    time_to(5, 100, n);
    chkb("relief", current_pct < 10'h096, 1'b1);
    do_reset();
    load(10'h000, 16'h0FA0, 4'b0100, 1'b1);
    idle(4);
    chk("ramp0", 16'(ramp_index), 16'h0000);
    wr(`REG_RAMP_FREQ, 16'h0BB8);
    idle(4);
    chk("ramp_up", 16'(ramp_index), 16'h0001);
    load(10'h000, 16'h07D0, 4'b0100, 1'b1);
    idle(4);
    chk("ramp_dn", 16'(ramp_index), 16'h0000);
    @(posedge clock);
    ramp_select_pins <= 3'b101;
    idle(6);
    chk("ramp_pin", 16'(ramp_index), 16'h0005);
    end_of_test();
  end
endmodule
